//--- csfe_encoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "csfe_consts.svh"
module csfe_encoder (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // audio samples in, alternating channel A then B
   input  wire logic        in_valid,
   output logic             in_ready,
   input  wire logic [23:0] in_sample,
   // subframes out toward the line coder
   output logic             out_valid,
   input  wire logic        out_ready,
   output logic [23:0]      out_sample,
   output logic             out_cs_bit,
   output logic [7:0]       out_frame,
   output logic             out_chan_b,
   output logic             out_block_start
);
   logic                        enable;
   logic [31:0]                 cs_low;
   logic [3:0]                  cs_high;
   logic [31:0]                 shadow_low;
   logic [3:0]                  shadow_high;
   logic [7:0]                  frame;
   csfe_pkg::csfe_channel_type  chan;
   logic                        fifo_valid;
   logic                        fifo_take;
   logic [23:0]                 fifo_data;
   logic                        load;
   logic                        load_first;
   csfe_pkg::csfe_cs_block_type cs_block;
   csfe_pkg::csfe_width_type    live_width;
   csfe_pkg::csfe_width_type    act_width;
   csfe_pkg::csfe_width_type    act_eff;
   csfe_pkg::csfe_width_type    live_eff;
   logic                        live_wlen_res;
   logic                        cat_reserved;
   logic [7:0]                  cat;
   logic [23:0]                 width_mask;
   logic [4:0]                  drop_bits;

   // sixteen-word buffer so bursty upstream writes ride over block stalls
   csfe_fifo #(
      .WIDTH (`CSFE_SAMPLE_W),
      .DEPTH (`CSFE_FIFO_DEPTH)
   ) u_fifo (
      .clk     (clk),
      .sys_rst (sys_rst),
      .s_valid (in_valid),
      .s_ready (in_ready),
      .s_data  (in_sample),
      .m_valid (fifo_valid),
      .m_ready (fifo_take),
      .m_data  (fifo_data)
   );

   // live decode feeds the reserved flag and a block's first subframe; the active decode drives the later subframes and status width
   csfe_wlen_decode u_wlen_live (
      .max_length_flag (cs_high[0]),
      .word_len_code   (cs_high[3:1]),
      .width           (live_width),
      .eff_width       (live_eff),
      .reserved        (live_wlen_res)
   );

   csfe_wlen_decode u_wlen_act (
      .max_length_flag (shadow_high[0]),
      .word_len_code   (shadow_high[3:1]),
      .width           (act_width),
      .eff_width       (act_eff),
      .reserved        ()
   );

   // output stage advances when empty or being drained
   assign load       = enable && fifo_valid && (!out_valid || out_ready);
   assign fifo_take  = load;
   assign load_first = load && (frame == 8'h00) && (chan == csfe_pkg::CSFE_CH_A);
   assign cs_block   = load_first ? {cs_high, cs_low} : {shadow_high, shadow_low};

   // classify the category byte; reserved codes are flagged, not rewritten
   assign cat = cs_low[`CSFE_CAT_MSB:`CSFE_CAT_LSB];
   always_comb begin
      cat_reserved = 1'b0;
      if (cat[2:0] == `CSFE_GRP_RESERVED) begin
         cat_reserved = 1'b1;
      end else if (cat[2:0] == `CSFE_GRP_GENERAL && !cat[3]) begin
         // all-zero general and the experimental subcode are allowed
         cat_reserved = (cat[6:0] != 7'h00) && (cat[6:3] != `CSFE_SUB_EXPERIM);
      end
   end

   // samples beyond the active length are cleared, never rounded
   // the block's first subframe already takes the new length, like its status bits
   assign drop_bits  = 5'(`CSFE_SAMPLE_W) - (load_first ? live_eff : act_eff);
   assign width_mask = 24'hFFFFFF << drop_bits;

   // control register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         enable <= `CSFE_CTRL_RST;
      end else if (reg_wr && reg_addr == `CSFE_ADDR_CTRL) begin
         enable <= reg_wdata[0];
      end
   end

   // software copy of the channel-status fields; reset gives general category
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cs_low  <= `CSFE_CS_LOW_RST;
         cs_high <= `CSFE_CS_HIGH_RST;
      end else if (reg_wr && reg_addr == `CSFE_ADDR_CS_LOW) begin
         cs_low                     <= reg_wdata;
         cs_low[`CSFE_CONSUMER_BIT] <= 1'b0;
         cs_low[`CSFE_PCM_BIT]      <= 1'b0;
      end else if (reg_wr && reg_addr == `CSFE_ADDR_CS_HIGH) begin
         cs_high <= reg_wdata[3:0];
      end
   end

   // snapshot at the first subframe of a block so one block never mixes settings
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         shadow_low  <= `CSFE_CS_LOW_RST;
         shadow_high <= `CSFE_CS_HIGH_RST;
      end else if (load_first) begin
         shadow_low  <= cs_low;
         shadow_high <= cs_high;
      end
   end

   // frame and channel position within the 192-frame block
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         frame <= 8'h00;
         chan  <= csfe_pkg::CSFE_CH_A;
      end else if (load) begin
         if (chan == csfe_pkg::CSFE_CH_B) begin
            chan  <= csfe_pkg::CSFE_CH_A;
            frame <= (frame == `CSFE_FRAMES_LAST) ? 8'h00 : frame + 8'h01;
         end else begin
            chan <= csfe_pkg::CSFE_CH_B;
         end
      end
   end

   // registered subframe; both channels carry the same status bit per frame
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         out_valid       <= 1'b0;
         out_sample      <= 24'h000000;
         out_cs_bit      <= 1'b0;
         out_frame       <= 8'h00;
         out_chan_b      <= 1'b0;
         out_block_start <= 1'b0;
      end else if (load) begin
         out_valid       <= 1'b1;
         out_sample      <= fifo_data & width_mask;
         out_cs_bit      <= (frame < 8'(`CSFE_CS_BITS)) ? cs_block[6'(frame)] : 1'b0;
         out_frame       <= frame;
         out_chan_b      <= (chan == csfe_pkg::CSFE_CH_B);
         out_block_start <= load_first;
      end else if (out_ready) begin
         out_valid <= 1'b0;
      end
   end

   // read data one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata <= 32'h00000000;
         case (reg_addr)
            `CSFE_ADDR_CTRL:    reg_rdata[0]   <= enable;
            `CSFE_ADDR_CS_LOW:  reg_rdata      <= cs_low;
            `CSFE_ADDR_CS_HIGH: reg_rdata[3:0] <= cs_high;
            `CSFE_ADDR_STATUS: begin
               reg_rdata[`CSFE_ST_RUN]                          <= enable && out_valid;
               reg_rdata[`CSFE_ST_CAT_RES]                      <= cat_reserved;
               reg_rdata[`CSFE_ST_WLEN_RES]                     <= live_wlen_res;
               reg_rdata[`CSFE_ST_WIDTH_MSB:`CSFE_ST_WIDTH_LSB] <= act_width;
               reg_rdata[`CSFE_ST_FRAME_MSB:`CSFE_ST_FRAME_LSB] <= frame;
            end
            default:            reg_rdata <= 32'h00000000;
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   AST_MAXLEN_20: assert property (!cs_high[0] && cs_high[3:1] == 3'h5 |-> live_width == `CSFE_W20)
      else $error("flag clear code 101 is not 20 bits");
   AST_WLEN_16: assert property (!cs_high[0] && cs_high[3:1] == 3'h1 |-> live_width == `CSFE_W16)
      else $error("code 001 is not 16 bits");
   AST_WLEN_24: assert property (cs_high[0] && cs_high[3:1] == 3'h5 |-> live_width == `CSFE_W24)
      else $error("code 101 with flag set is not 24 bits");
   AST_MASK: assert property (out_valid |-> (out_sample & ~(24'hFFFFFF << (5'(`CSFE_SAMPLE_W) - act_eff))) == 24'h000000)
      else $error("sample bits below the active length leak out");
   AST_CHAN_SRC: assert property (load && !load_first && frame >= 8'h10 && frame <= 8'h17
                                  |=> out_cs_bit == shadow_low[5'($past(frame))])
      else $error("channel or source bit mismatch");
   AST_CAT_RES: assert property (cs_low[10:8] == `CSFE_GRP_RESERVED |-> cat_reserved)
      else $error("group 111 not flagged reserved");
   AST_ADC_OK: assert property (cs_low[10:8] == 3'h6 && cs_low[11] == 1'b0 |-> !cat_reserved)
      else $error("converter subcode wrongly flagged");
   AST_SOLID: assert property (cs_low[10:8] == `CSFE_GRP_GENERAL && cs_low[11] |-> !cat_reserved)
      else $error("solid-state memory code flagged reserved");
   AST_GENERAL: assert property (cat == 8'h00 |-> !cat_reserved)
      else $error("general category flagged reserved");
   AST_GEN_BIT: assert property (load && !load_first && frame == 8'h0F |=> out_cs_bit == shadow_low[`CSFE_GEN_BIT])
      else $error("generation bit not sent at position 15");
   AST_CONSUMER: assert property (out_valid && out_frame <= 8'h01 |-> !out_cs_bit)
      else $error("consumer or PCM bit not zero");
   AST_SNAPSHOT: assert property ($changed(shadow_low) || $changed(shadow_high) |-> $past(load_first))
      else $error("fields changed inside a block");

   COV_BLOCK_START: cover property (load_first ##1 out_block_start);
   COV_BLOCK_WRAP: cover property (load && frame == `CSFE_FRAMES_LAST && chan == csfe_pkg::CSFE_CH_B);
   COV_MID_UPDATE: cover property (reg_wr && reg_addr == `CSFE_ADDR_CS_LOW && frame != 8'h00);
   COV_STALL: cover property (out_valid && !out_ready && !in_ready);
endmodule : csfe_encoder
`default_nettype wire

//--- csfe_consts.svh
`ifndef CSFE_CONSTS_SVH
`define CSFE_CONSTS_SVH

// register byte addresses
`define CSFE_ADDR_CTRL      8'h00
`define CSFE_ADDR_CS_LOW    8'h04
`define CSFE_ADDR_CS_HIGH   8'h08
`define CSFE_ADDR_STATUS    8'h0C

// reset values
`define CSFE_CTRL_RST       1'h0
`define CSFE_CS_LOW_RST     32'h00000000
`define CSFE_CS_HIGH_RST    4'h0

// channel-status field positions
`define CSFE_CONSUMER_BIT   0
`define CSFE_PCM_BIT        1
`define CSFE_CAT_LSB        8
`define CSFE_CAT_MSB        15
`define CSFE_GEN_BIT        15
`define CSFE_SRC_LSB        16
`define CSFE_CHAN_MSB       23
`define CSFE_CS_BITS        40

// status register fields
`define CSFE_ST_RUN         0
`define CSFE_ST_CAT_RES     1
`define CSFE_ST_WLEN_RES    2
`define CSFE_ST_WIDTH_LSB   4
`define CSFE_ST_WIDTH_MSB   8
`define CSFE_ST_FRAME_LSB   16
`define CSFE_ST_FRAME_MSB   23

// block geometry and sample widths
`define CSFE_FRAMES_LAST    8'hBF
`define CSFE_SAMPLE_W       24
`define CSFE_FIFO_DEPTH     16
`define CSFE_W_NONE         5'h00
`define CSFE_W16            5'h10
`define CSFE_W17            5'h11
`define CSFE_W18            5'h12
`define CSFE_W19            5'h13
`define CSFE_W20            5'h14
`define CSFE_W21            5'h15
`define CSFE_W22            5'h16
`define CSFE_W23            5'h17
`define CSFE_W24            5'h18

// category group codes
`define CSFE_GRP_GENERAL    3'h0
`define CSFE_GRP_RESERVED   3'h7
`define CSFE_SUB_EXPERIM    4'h8

`endif

//--- csfe_pkg.sv
package csfe_pkg;
   typedef logic [39:0] csfe_cs_block_type;
   typedef logic [4:0]  csfe_width_type;
   typedef enum logic [0:0] {
      CSFE_CH_A = 1'h0,
      CSFE_CH_B = 1'h1
   } csfe_channel_type;
endpackage : csfe_pkg

//--- csfe_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module csfe_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             s_valid,
   output logic                  s_ready,
   input  wire logic [WIDTH-1:0] s_data,
   output logic                  m_valid,
   input  wire logic             m_ready,
   output logic [WIDTH-1:0]      m_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   // honest full and empty from the word count
   assign s_ready = (count != (AW+1)'(DEPTH));
   assign m_valid = (count != '0);
   assign push    = s_valid && s_ready;
   assign pop     = m_valid && m_ready;
   assign m_data  = mem[rd_ptr];

   // storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= s_data;
      end
   end

   // pointers wrap naturally since depth is a power of two
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule : csfe_fifo
`default_nettype wire

//--- csfe_wlen_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "csfe_consts.svh"
module csfe_wlen_decode (
   input  wire logic          max_length_flag,
   input  wire logic [2:0]    word_len_code,
   output csfe_pkg::csfe_width_type width,
   output csfe_pkg::csfe_width_type eff_width,
   output logic               reserved
);
   // decode the three-bit code relative to the maximum-length flag
   always_comb begin
      reserved = 1'b0;
      case ({max_length_flag, word_len_code})
         4'h0:    width = `CSFE_W_NONE;
         4'h1:    width = `CSFE_W16;
         4'h2:    width = `CSFE_W18;
         4'h4:    width = `CSFE_W19;
         4'h5:    width = `CSFE_W20;
         4'h6:    width = `CSFE_W17;
         4'h8:    width = `CSFE_W_NONE;
         4'h9:    width = `CSFE_W20;
         4'hA:    width = `CSFE_W22;
         4'hC:    width = `CSFE_W23;
         4'hD:    width = `CSFE_W24;
         4'hE:    width = `CSFE_W21;
         default: begin
            width    = `CSFE_W_NONE;
            reserved = 1'b1;
         end
      endcase
   end

   // unknown or reserved length falls back to the flagged maximum
   assign eff_width = (width != `CSFE_W_NONE) ? width :
                      (max_length_flag ? `CSFE_W24 : `CSFE_W20);
endmodule : csfe_wlen_decode
`default_nettype wire

//--- csfe_receiver_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural far-side receiver: stalls one cycle in STALL_EVERY and rebuilds each status block
module csfe_receiver_model #(
   parameter int STALL_EVERY = 4
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        out_valid,
   output logic             out_ready,
   input  wire logic [23:0] out_sample,
   input  wire logic        out_cs_bit,
   input  wire logic [7:0]  out_frame,
   input  wire logic        out_chan_b,
   input  wire logic        out_block_start,
   output int               starts,
   output int               ends,
   output int               seq_err,
   output logic [23:0]      first_sample,
   output logic [39:0]      last_cs
);
   int          tick;
   logic [7:0]  want_frame;
   logic        want_b;
   logic        a_cs;
   logic [39:0] cs_acc;

   // ready is a level, so stalling on a fixed beat keeps the sender's hold logic busy
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tick      <= 0;
         out_ready <= 1'b0;
      end else begin
         tick      <= tick + 1;
         out_ready <= (tick % STALL_EVERY) != 0;
      end
   end

   // track frame order, pairing of a/b, and assemble the status bits of each block
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         want_frame <= 8'h00;
         want_b     <= 1'b0;
         starts     <= 0;
         ends       <= 0;
         seq_err    <= 0;
         cs_acc     <= 40'h0000000000;
      end else if (out_valid && out_ready) begin
         if (out_frame !== want_frame || out_chan_b !== want_b ||
             out_block_start !== (out_frame == 8'h00 && !out_chan_b) ||
             (out_chan_b && out_cs_bit !== a_cs)) begin
            seq_err <= seq_err + 1;
         end
         want_b     <= ~out_chan_b;
         want_frame <= out_chan_b ? ((out_frame == 8'hBF) ? 8'h00 : out_frame + 8'h01) : out_frame;
         if (!out_chan_b) begin
            a_cs <= out_cs_bit;
            if (out_frame < 8'h28) begin
               cs_acc[out_frame] <= out_cs_bit;
            end
         end
         if (out_block_start) begin
            starts       <= starts + 1;
            first_sample <= out_sample;
         end
         if (out_chan_b && out_frame == 8'hBF) begin
            ends    <= ends + 1;
            last_cs <= cs_acc;
         end
      end
   end
endmodule : csfe_receiver_model
`default_nettype wire

//--- csfe_encoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "csfe_consts.svh"
module csfe_encoder_tb_top;
   logic        clk;
   logic        sys_rst;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        in_valid;
   logic        in_ready;
   logic        feed;
   logic        out_valid;
   logic        out_ready;
   logic [23:0] out_sample;
   logic        out_cs_bit;
   logic [7:0]  out_frame;
   logic        out_chan_b;
   logic        out_block_start;
   logic [23:0] first_sample;
   logic [39:0] last_cs;
   logic [4:0]  w;
   logic [2:0]  c;
   logic        f;
   int          starts;
   int          ends;
   int          seq_err;
   int          accepted;
   int          failures;
   int          compares;
   int          i;
   int          n;
   logic [7:0]  cats [12] = '{8'h00, 8'h80, 8'h08, 8'h40, 8'hC0, 8'h10, 8'h07, 8'h87, 8'h06, 8'h16, 8'h01, 8'h05};
   logic        cres [12] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

   initial clk = 1'b0;
   always #2.5 clk = ~clk;

   csfe_encoder csfe_encoder_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready),
      .in_sample(24'hFFFFFF), .out_valid(out_valid), .out_ready(out_ready), .out_sample(out_sample),
      .out_cs_bit(out_cs_bit), .out_frame(out_frame), .out_chan_b(out_chan_b), .out_block_start(out_block_start));

   csfe_receiver_model csfe_receiver_model_i (.clk(clk), .sys_rst(sys_rst), .out_valid(out_valid),
      .out_ready(out_ready), .out_sample(out_sample), .out_cs_bit(out_cs_bit), .out_frame(out_frame),
      .out_chan_b(out_chan_b), .out_block_start(out_block_start), .starts(starts), .ends(ends),
      .seq_err(seq_err), .first_sample(first_sample), .last_cs(last_cs));

   // full-scale samples make any truncation of the word visible at the output
   always @(posedge clk) begin
      if (sys_rst) begin
         accepted <= 0;
         in_valid <= 1'b0;
      end else begin
         if (in_valid && in_ready) begin
            accepted <= accepted + 1;
         end
         in_valid <= feed;
      end
   end

   // expected decoded width, zero when not indicated or reserved
   function automatic logic [4:0] wl(input logic fl, input logic [2:0] cd);
      case (cd)
         3'h1: wl = fl ? 5'h14 : 5'h10;
         3'h2: wl = fl ? 5'h16 : 5'h12;
         3'h4: wl = fl ? 5'h17 : 5'h13;
         3'h5: wl = fl ? 5'h18 : 5'h14;
         3'h6: wl = fl ? 5'h15 : 5'h11;
         default: wl = 5'h00;
      endcase
   endfunction : wl

   task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   // read data update at the edge that samples the strobe and hold until the next read, so sample just past that edge
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input string what);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      check(what, {8'h00, exp & m}, {8'h00, reg_rdata & m});
   endtask : rd

   // wait for n more block starts (which=0) or block ends (which=1), bounded
   task automatic wait_evt(input logic which, input int cnt);
      int t0;
      int k;
      t0 = which ? ends : starts;
      for (k = 0; k < 4000 && (which ? ends : starts) < t0 + cnt; k++) begin
         @(posedge clk);
      end
      #1;
      // a wait that runs out counts as a mismatch here
      check("event count", 40'(t0 + cnt), 40'(which ? ends : starts));
   endtask : wait_evt

   task automatic close_out;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   initial begin
      #(5 * 60000);
      failures++;
      $display("watchdog expired");
      close_out;
   end

   initial begin
      sys_rst   = 1'b1;
      reg_addr  = 8'h00;
      reg_wdata = 32'h00000000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      feed      = 1'b0;
      failures  = 0;
      compares  = 0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      // reset values, unmapped place, forced-zero bits, live reserved flags
      for (i = 0; i < 4; i++) rd(8'(i * 4), 32'h00000000, 32'hFFFFFFFF, "reset value");
      wr(8'h10, 32'hFFFFFFFF);
      rd(8'h10, 32'h00000000, 32'hFFFFFFFF, "unmapped");
      wr(`CSFE_ADDR_CS_LOW, 32'hFFFFFFFF);
      rd(`CSFE_ADDR_CS_LOW, 32'hFFFFFFFC, 32'hFFFFFFFF, "cs low");
      wr(`CSFE_ADDR_CS_HIGH, 32'hFFFFFFFF);
      rd(`CSFE_ADDR_CS_HIGH, 32'h0000000F, 32'hFFFFFFFF, "cs high");
      rd(`CSFE_ADDR_STATUS, 32'h00000006, 32'h00000006, "reserved flags");
      for (i = 0; i < 12; i++) begin
         wr(`CSFE_ADDR_CS_LOW, {16'h0000, cats[i], 8'h00});
         rd(`CSFE_ADDR_STATUS, {30'h0, cres[i], 1'b0}, 32'h00000002, "category");
      end
      $display("test registers done");
      // fill the buffer while disabled until it refuses
      feed <= 1'b1;
      for (i = 0; i < 100 && in_ready !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      check("fill count", 40'h10, {8'h00, 32'(accepted)});
      check("in_ready full", 40'h0, {39'h0, in_ready});
      check("out_valid idle", 40'h0, {39'h0, out_valid});
      $display("test fifo fill done");
      // every word-length code under both maximum lengths
      wr(`CSFE_ADDR_CTRL, 32'h00000001);
      wr(`CSFE_ADDR_CS_LOW, 32'h002F8600);
      for (i = 0; i < 16; i++) begin
         f = i[0];
         c = i[3:1];
         w = wl(f, c);
         n = (w == 5'h00) ? (f ? 24 : 20) : int'(w);
         wr(`CSFE_ADDR_CS_HIGH, {28'h0, 4'(i)});
         wait_evt(1'b0, 2);
         check("first sample", {16'h0, 24'hFFFFFF << (24 - n)}, {16'h0, first_sample});
         rd(`CSFE_ADDR_STATUS, {23'h0, w, 1'b0, (c == 3'h3 || c == 3'h7), 2'h0}, 32'h000001F4, "width");
      end
      $display("test word length done");
      // whole block content, then a change made in mid-block
      wr(`CSFE_ADDR_CS_HIGH, 32'h0000000B);
      wait_evt(1'b1, 2);
      check("cs block", {8'h0B, 32'h002F8600}, last_cs);
      wait_evt(1'b0, 1);
      repeat (100) @(posedge clk);
      rd(`CSFE_ADDR_STATUS, 32'h00000001, 32'h00000001, "run flag");
      wr(`CSFE_ADDR_CS_LOW, 32'h00110707);
      wait_evt(1'b1, 1);
      check("cs block old", {8'h0B, 32'h002F8600}, last_cs);
      wait_evt(1'b1, 1);
      check("cs block new", {8'h0B, 32'h00110704}, last_cs);
      $display("test block content done");
      // drain with the receiver still stalling
      feed <= 1'b0;
      for (i = 0; i < 200 && (out_valid !== 1'b0 || in_ready !== 1'b1); i++) begin
         @(posedge clk);
         #1;
      end
      check("drained", 40'h1, {38'h0, out_valid, in_ready});
      check("frame order", 40'h0, {8'h00, 32'(seq_err)});
      rd(`CSFE_ADDR_STATUS, 32'h00000000, 32'h00000001, "run flag idle");
      $display("test drain done");
      close_out;
   end
endmodule : csfe_encoder_tb_top
`default_nettype wire
